/* File: rtl/conv_sequencer.sv */
`timescale 1ns/100ps
module conv_sequencer import monitor_pkg::*; #(
  parameter int unsigned TEMP_CONV_CYC = TEMP_CONV_CYC_DEF,
  parameter int unsigned VOLT_CONV_CYC = VOLT_CONV_CYC_DEF,
  parameter int unsigned IDLE_UNIT_CYC = IDLE_UNIT_CYC_DEF,
  parameter bit          EXTERNAL_VOLTAGE_INPUT_2_FIRST    = 1'b1
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       standby,
  input  wire logic       temp_dis,
  input  wire logic       volt_dis,
  input  wire logic [2:0] rate,
  input  wire logic [7:0] adc_sample,
  input  wire logic [2:0] rd_idx,
  output logic      [7:0] rd_data,
  output logic            busy_ff,
  output logic      [2:0] conv_ch_ff
);

  seq_state_t  state_ff;
  logic [2:0]  slot_ff;
  logic [31:0] slot_cnt_ff;
  logic [31:0] idle_cnt_ff;
  logic [7:0]  res_ff [NUM_CH];
  logic [7:0]  shadow_ff [NUM_CH];
  logic [31:0] idle_target;
  logic [3:0]  first_slot;
  logic [3:0]  next_slot;
  logic        start;
  logic        slot_end;
  logic        commit;

  // Slot to channel, variant picks supply position
  function automatic logic [2:0] slot_ch(input logic [2:0] s);
    case (s)
      3'h0:    slot_ch = CH_REM1;
      3'h1:    slot_ch = CH_REM2;
      3'h2:    slot_ch = CH_LOCAL;
      3'h3:    slot_ch = CH_EXTERNAL_VOLTAGE_INPUT_3;
      3'h4:    slot_ch = EXTERNAL_VOLTAGE_INPUT_2_FIRST ? CH_EXTERNAL_VOLTAGE_INPUT_2 : CH_VCC;
      3'h5:    slot_ch = CH_EXTERNAL_VOLTAGE_INPUT_1;
      default: slot_ch = EXTERNAL_VOLTAGE_INPUT_2_FIRST ? CH_VCC : CH_EXTERNAL_VOLTAGE_INPUT_2;
    endcase
  endfunction : slot_ch

  // First enabled slot at or after from; bit 3 marks found
  function automatic logic [3:0] find_slot(input logic [3:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (4'(i) >= from && ((i < 3) ? !temp_dis : !volt_dis)) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : find_slot

  // Cycle control terms
  assign idle_target = IDLE_UNIT_CYC << rate;
  assign first_slot  = find_slot(4'h0);
  assign next_slot   = find_slot({1'b0, slot_ff} + 4'h1);
  assign start       = state_ff == SQ_IDLE && !standby && idle_cnt_ff >= idle_target
                       && first_slot[3];
  assign slot_end    = state_ff == SQ_CONV && !standby && slot_cnt_ff == 32'h0;
  assign commit      = slot_end && !next_slot[3];

  // Sequencing state, slot timer and rate timer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff    <= SQ_IDLE;
      slot_ff     <= 3'h0;
      slot_cnt_ff <= 32'h0;
      idle_cnt_ff <= 32'h0;
      busy_ff     <= 1'b0;
      conv_ch_ff  <= CH_REM1;
    end else begin
      case (state_ff)
        SQ_IDLE: begin
          if (standby) begin
            idle_cnt_ff <= idle_target;
          end else if (start) begin
            state_ff    <= SQ_CONV;
            slot_ff     <= first_slot[2:0];
            conv_ch_ff  <= slot_ch(first_slot[2:0]);
            slot_cnt_ff <= (first_slot[2:0] < 3'h3 ? TEMP_CONV_CYC : VOLT_CONV_CYC) - 1;
            busy_ff     <= 1'b1;
            idle_cnt_ff <= 32'h0;
          end else if (idle_cnt_ff < idle_target) begin
            idle_cnt_ff <= idle_cnt_ff + 32'h1;
          end
        end
        SQ_CONV: begin
          if (standby) begin
            state_ff    <= SQ_IDLE;
            busy_ff     <= 1'b0;
            idle_cnt_ff <= idle_target;
          end else if (commit) begin
            state_ff    <= SQ_IDLE;
            busy_ff     <= 1'b0;
            idle_cnt_ff <= 32'h1;
          end else if (slot_end) begin
            slot_ff     <= next_slot[2:0];
            conv_ch_ff  <= slot_ch(next_slot[2:0]);
            slot_cnt_ff <= (next_slot[2:0] < 3'h3 ? TEMP_CONV_CYC : VOLT_CONV_CYC) - 1;
          end else begin
            slot_cnt_ff <= slot_cnt_ff - 32'h1;
          end
        end
        default: state_ff <= SQ_IDLE;
      endcase
    end
  end

  // Shadow capture per slot, publish whole cycle at commit
  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (reset) begin
        res_ff[c]    <= 8'h00;
        shadow_ff[c] <= 8'h00;
      end else if (start) begin
        shadow_ff[c] <= res_ff[c];
      end else if (slot_end && 3'(c) == conv_ch_ff) begin
        shadow_ff[c] <= adc_sample;
        if (commit) res_ff[c] <= adc_sample;
      end else if (commit) begin
        res_ff[c] <= shadow_ff[c];
      end
    end
  end

  assign rd_data = (rd_idx < 3'(NUM_CH)) ? res_ff[rd_idx] : 8'h00;

  chk_abort_clears_busy: assert property (@(posedge clk_sys) disable iff (reset)
    standby |=> !busy_ff && state_ff == SQ_IDLE) else $error("busy kept in standby");
  chk_start_sets_busy: assert property (@(posedge clk_sys) disable iff (reset)
    start |=> busy_ff && slot_cnt_ff >= VOLT_CONV_CYC - 1) else $error("cycle start lost");
  chk_skip_temp: assert property (@(posedge clk_sys) disable iff (reset)
    (start || slot_end) && temp_dis |=> !busy_ff || slot_ff >= 3'h3)
    else $error("disabled temperature slot converted");
  chk_results_stable: assert property (@(posedge clk_sys) disable iff (reset)
    !commit |=> $stable(res_ff[CH_LOCAL]) && $stable(res_ff[CH_REM1]))
    else $error("results changed outside commit");
  chk_temp_slot_len: assert property (@(posedge clk_sys) disable iff (reset)
    start && first_slot[2:0] < 3'h3 |=> slot_cnt_ff == TEMP_CONV_CYC - 1)
    else $error("temperature slot length wrong");
  cov_full_cycle: cover property (@(posedge clk_sys) disable iff (reset) commit);
  cov_abort: cover property (@(posedge clk_sys) disable iff (reset) busy_ff && standby);

endmodule : conv_sequencer

/* File: rtl/monitor_pkg.sv */
// Operation
// - Write Byte, Read Byte, Send Byte, Receive Byte; 7-bit address, bytes acknowledged.
// - Last command byte of Write or Read Byte is kept as pointer.
// - All values appear as byte registers selected by the command byte.
// - A cycle converts all enabled channels; results publish when it ends.
// - Busy shows while converting; reads return the previous complete results.
// - Order: remote 1, remote 2, local, input 3, input 2/supply, input 1, supply/input 2.
// - Conversions run full speed; only the idle gap follows the rate register.
// - Disabled temperature or voltage channels are skipped, shortening the cycle.
// - Standby when standby pin is low or software stop bit set.
// - Standby keeps all registers; the serial interface stays fully usable.
// - Low standby pin overrides software; device stays idle while low.
// - Standby during a cycle aborts it; partial results are dropped.
// - Each temperature slot lasts 125 ms.
// - Rate timer runs between cycles and starts the next when elapsed.
// - Command pointer is zero after reset; Receive Byte reads local temperature.
// - Alert response address read returns own address when alert pending.
package monitor_pkg;

  // Conversion timing
  localparam int CLK_MHZ           = 200;
  localparam int TEMP_CONV_MS      = 125;
  localparam int VOLT_CONV_US      = 62500;
  localparam int TEMP_CONV_CYC_DEF = TEMP_CONV_MS * 1000 * CLK_MHZ;
  localparam int VOLT_CONV_CYC_DEF = VOLT_CONV_US * CLK_MHZ;
  localparam int IDLE_UNIT_CYC_DEF = TEMP_CONV_CYC_DEF;

  // Bus constants
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
  localparam logic [3:0] BYTE_BITS       = 4'h8;
  localparam logic [7:0] CMD_PTR_RST     = 8'h00;

  // Command map of local registers
  localparam logic [7:0] CMD_STATUS = 8'h07;
  localparam logic [7:0] CMD_CONFIG = 8'h08;
  localparam logic [7:0] CMD_RATE   = 8'h09;
  localparam int         NUM_CH     = 7;

  // Field positions and reset values
  localparam int         CFG_STOP_BIT  = 6;
  localparam int         CFG_TDIS_BIT  = 5;
  localparam int         CFG_VDIS_BIT  = 4;
  localparam int         STAT_BUSY_BIT = 7;
  localparam logic [7:0] CONFIG_RST    = 8'h00;
  localparam logic [2:0] RATE_RST      = 3'h2;

  // Channel result indices
  localparam logic [2:0] CH_LOCAL = 3'h0;
  localparam logic [2:0] CH_REM1  = 3'h1;
  localparam logic [2:0] CH_REM2  = 3'h2;
  localparam logic [2:0] CH_EXTERNAL_VOLTAGE_INPUT_3  = 3'h3;
  localparam logic [2:0] CH_EXTERNAL_VOLTAGE_INPUT_2  = 3'h4;
  localparam logic [2:0] CH_EXTERNAL_VOLTAGE_INPUT_1  = 3'h5;
  localparam logic [2:0] CH_VCC   = 3'h6;

  typedef enum logic [1:0] {SQ_IDLE = 2'b01, SQ_CONV = 2'b10} seq_state_t;

  typedef enum logic [8:0] {
    B_IDLE = 9'b000000001,
    B_ADDR = 9'b000000010,
    B_AACK = 9'b000000100,
    B_CMD  = 9'b000001000,
    B_CACK = 9'b000010000,
    B_WDAT = 9'b000100000,
    B_WACK = 9'b001000000,
    B_RDAT = 9'b010000000,
    B_RACK = 9'b100000000
  } bus_state_t;

endpackage : monitor_pkg

/* File: rtl/monitor_smbus_conversion_control.sv */
`timescale 1ns/100ps
module monitor_smbus_conversion_control import monitor_pkg::*; #(
  parameter int unsigned TEMP_CONV_CYC = TEMP_CONV_CYC_DEF,
  parameter int unsigned VOLT_CONV_CYC = VOLT_CONV_CYC_DEF,
  parameter int unsigned IDLE_UNIT_CYC = IDLE_UNIT_CYC_DEF,
  parameter bit          EXTERNAL_VOLTAGE_INPUT_2_FIRST    = 1'b1
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       smb_clk,
  input  wire logic       smb_data_in,
  output logic            smb_data_out,
  output logic            smb_data_oe,
  input  wire logic       standby_request_pin_n,
  input  wire logic [6:0] slave_addr,
  input  wire logic       alert_pending,
  input  wire logic [7:0] adc_sample,
  input  wire logic [7:0] ext_rd_data,
  output logic            reg_wr_stb,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            alert_served,
  output logic            busy,
  output logic            standby,
  output logic      [2:0] conv_channel
);

  logic [9:0] sync_vec;
  logic       s_scl;
  logic       s_sda;
  logic       s_standby_request_pin_n_n;
  logic [6:0] s_addr;
  logic       p_scl_ff;
  logic       p_sda_ff;
  logic       ev_start;
  logic       ev_stop;
  logic       ev_rise;
  logic       ev_fall;
  logic       byte_done;

  bus_state_t bst_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic       rd_dir_ff;
  logic       alert_resp_ff;
  logic [7:0] cmd_ptr_ff;
  logic       sda_oe_ff;
  logic       sda_out_ff;
  logic [7:0] config_ff;
  logic [2:0] rate_ff;
  logic       standby_ff;
  logic       wr_stb_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] wr_data_ff;
  logic       alert_served_ff;
  logic [7:0] seq_rd_data;
  logic       seq_busy;
  logic [2:0] seq_ch;
  logic       addr_hit;
  logic       alert_hit;
  logic       wr_event;
  logic [7:0] tx_byte;

  // Pins from outside the clock domain
  sync_two_ff #(
    .WIDTH   (10),
    .RST_VAL (10'h380)
  ) u_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in ({smb_clk, smb_data_in, standby_request_pin_n, slave_addr}),
    .sync_out (sync_vec)
  );

  assign s_scl    = sync_vec[9];
  assign s_sda    = sync_vec[8];
  assign s_standby_request_pin_n_n = sync_vec[7];
  assign s_addr   = sync_vec[6:0];

  // Conversion sequencer with result storage
  conv_sequencer #(
    .TEMP_CONV_CYC (TEMP_CONV_CYC),
    .VOLT_CONV_CYC (VOLT_CONV_CYC),
    .IDLE_UNIT_CYC (IDLE_UNIT_CYC),
    .EXTERNAL_VOLTAGE_INPUT_2_FIRST    (EXTERNAL_VOLTAGE_INPUT_2_FIRST)
  ) u_seq (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .standby    (standby_ff),
    .temp_dis   (config_ff[CFG_TDIS_BIT]),
    .volt_dis   (config_ff[CFG_VDIS_BIT]),
    .rate       (rate_ff),
    .adc_sample (adc_sample),
    .rd_idx     (cmd_ptr_ff[2:0]),
    .rd_data    (seq_rd_data),
    .busy_ff    (seq_busy),
    .conv_ch_ff (seq_ch)
  );

  // Register read decode by command byte
  function automatic logic [7:0] read_reg(input logic [7:0] cmd);
    logic [7:0] r;
    r = ext_rd_data;
    if (cmd < 8'(NUM_CH)) begin
      r = seq_rd_data;
    end else if (cmd == CMD_STATUS) begin
      r = 8'h00;
      r[STAT_BUSY_BIT] = seq_busy;
    end else if (cmd == CMD_CONFIG) begin
      r = config_ff;
    end else if (cmd == CMD_RATE) begin
      r = {5'h00, rate_ff};
    end
    return r;
  endfunction : read_reg

  // Previous line levels for edge and condition detect
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      p_scl_ff <= 1'b1;
      p_sda_ff <= 1'b1;
    end else begin
      p_scl_ff <= s_scl;
      p_sda_ff <= s_sda;
    end
  end

  // Bus conditions
  assign ev_start  = p_scl_ff && s_scl && p_sda_ff && !s_sda;
  assign ev_stop   = p_scl_ff && s_scl && !p_sda_ff && s_sda;
  assign ev_rise   = !p_scl_ff && s_scl;
  assign ev_fall   = p_scl_ff && !s_scl;
  assign byte_done = ev_fall && bit_cnt_ff == BYTE_BITS;

  // Address match, own or alert response
  assign addr_hit  = shift_ff[7:1] == s_addr;
  assign alert_hit = shift_ff[7:1] == ALERT_RESP_ADDR && shift_ff[0] && alert_pending;
  assign wr_event  = bst_ff == B_WDAT && byte_done;
  assign tx_byte   = alert_resp_ff ? {s_addr, 1'b0} : read_reg(cmd_ptr_ff);

  // Slave byte engine
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bst_ff        <= B_IDLE;
      bit_cnt_ff    <= 4'h0;
      shift_ff      <= 8'h00;
      tx_ff         <= 8'h00;
      rd_dir_ff     <= 1'b0;
      alert_resp_ff <= 1'b0;
      sda_oe_ff     <= 1'b0;
    end else if (ev_start) begin
      bst_ff        <= B_ADDR;
      bit_cnt_ff    <= 4'h0;
      sda_oe_ff     <= 1'b0;
      alert_resp_ff <= 1'b0;
    end else if (ev_stop) begin
      bst_ff    <= B_IDLE;
      sda_oe_ff <= 1'b0;
    end else begin
      case (bst_ff)
        B_ADDR, B_CMD, B_WDAT: begin
          if (ev_rise && bit_cnt_ff != BYTE_BITS) begin
            shift_ff   <= {shift_ff[6:0], s_sda};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (byte_done) begin
            bit_cnt_ff <= 4'h0;
            if (bst_ff == B_ADDR) begin
              if (addr_hit || alert_hit) begin
                sda_oe_ff     <= 1'b1;
                bst_ff        <= B_AACK;
                rd_dir_ff     <= shift_ff[0];
                alert_resp_ff <= alert_hit && !addr_hit;
              end else begin
                bst_ff <= B_IDLE;
              end
            end else begin
              sda_oe_ff <= 1'b1;
              bst_ff    <= (bst_ff == B_CMD) ? B_CACK : B_WACK;
            end
          end
        end
        B_AACK: begin
          if (ev_fall) begin
            if (rd_dir_ff) begin
              sda_oe_ff <= !tx_byte[7];
              tx_ff     <= {tx_byte[6:0], 1'b0};
              bst_ff    <= B_RDAT;
            end else begin
              sda_oe_ff <= 1'b0;
              bst_ff    <= B_CMD;
            end
          end
        end
        B_CACK: begin
          if (ev_fall) begin
            sda_oe_ff <= 1'b0;
            bst_ff    <= B_WDAT;
          end
        end
        B_WACK: begin
          if (ev_fall) begin
            sda_oe_ff <= 1'b0;
            bst_ff    <= B_IDLE;
          end
        end
        B_RDAT: begin
          if (ev_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (byte_done) begin
            sda_oe_ff <= 1'b0;
            bst_ff    <= B_RACK;
          end else if (ev_fall) begin
            sda_oe_ff <= !tx_ff[7];
            tx_ff     <= {tx_ff[6:0], 1'b0};
          end
        end
        B_RACK: begin
          if (ev_rise) begin
            bst_ff <= B_IDLE;
          end
        end
        default: bst_ff <= B_IDLE;
      endcase
    end
  end

  // Command pointer, kept for Send and Receive Byte
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmd_ptr_ff <= CMD_PTR_RST;
    end else if (bst_ff == B_CMD && byte_done && !ev_start && !ev_stop) begin
      cmd_ptr_ff <= shift_ff;
    end
  end

  // Write strobe to register space and local config
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_stb_ff  <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
      config_ff  <= CONFIG_RST;
      rate_ff    <= RATE_RST;
    end else begin
      wr_stb_ff <= wr_event && !ev_start && !ev_stop;
      if (wr_event && !ev_start && !ev_stop) begin
        wr_addr_ff <= cmd_ptr_ff;
        wr_data_ff <= shift_ff;
        if (cmd_ptr_ff == CMD_CONFIG) config_ff <= shift_ff;
        if (cmd_ptr_ff == CMD_RATE) rate_ff <= shift_ff[2:0];
      end
    end
  end

  // Standby from pin or software stop; registers untouched
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      standby_ff <= 1'b0;
    end else begin
      standby_ff <= !s_standby_request_pin_n_n || config_ff[CFG_STOP_BIT];
    end
  end

  // Alert response completion pulse
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      alert_served_ff <= 1'b0;
    end else begin
      alert_served_ff <= bst_ff == B_RACK && ev_rise && alert_resp_ff && !ev_start
                         && !ev_stop;
    end
  end

  // Open-drain data only ever pulls low
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sda_out_ff <= 1'b0;
    end else begin
      sda_out_ff <= 1'b0;
    end
  end

  // Output wiring
  assign smb_data_out = sda_out_ff;
  assign smb_data_oe  = sda_oe_ff;
  assign reg_wr_stb   = wr_stb_ff;
  assign reg_addr     = wr_addr_ff;
  assign reg_wdata    = wr_data_ff;
  assign alert_served = alert_served_ff;
  assign busy         = seq_busy;
  assign standby      = standby_ff;
  assign conv_channel = seq_ch;

  chk_ack_driven: assert property (@(posedge clk_sys) disable iff (reset)
    bst_ff == B_AACK || bst_ff == B_CACK || bst_ff == B_WACK |-> sda_oe_ff)
    else $error("acknowledge not driven");
  chk_cmd_store: assert property (@(posedge clk_sys) disable iff (reset)
    bst_ff == B_CMD && byte_done && !ev_start && !ev_stop |=> cmd_ptr_ff == $past(shift_ff))
    else $error("command pointer not stored");
  chk_pin_standby: assert property (@(posedge clk_sys) disable iff (reset)
    !s_standby_request_pin_n_n |=> standby_ff ##1 !seq_busy) else $error("pin low did not force standby");
  chk_ptr_reset: assert property (@(posedge clk_sys)
    $past(reset) |-> cmd_ptr_ff == 8'h00) else $error("pointer not zero after reset");
  chk_alert_reply: assert property (@(posedge clk_sys) disable iff (reset)
    bst_ff == B_AACK && ev_fall && rd_dir_ff && alert_resp_ff
    |=> tx_ff == {s_addr[5:0], 2'b00}) else $error("alert reply not own address");
  cov_read_byte: cover property (@(posedge clk_sys) disable iff (reset)
    bst_ff == B_RACK && ev_rise && s_sda);
  cov_write_byte: cover property (@(posedge clk_sys) disable iff (reset) wr_stb_ff);

endmodule : monitor_smbus_conversion_control

/* File: rtl/sync_two_ff.sv */
`timescale 1ns/100ps
module sync_two_ff #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // Two flops per bit; first stage read only by second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          meta_ff[i] <= RST_VAL[i];
          sync_ff[i] <= RST_VAL[i];
        end else begin
          meta_ff[i] <= async_in[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_ff;

endmodule : sync_two_ff

/* File: tb/monitor_smbus_conversion_control_test.sv */
`timescale 1ns/100ps
module monitor_smbus_conversion_control_test import monitor_pkg::*; ;
  localparam int         TC  = 20;
  localparam int         VC  = 10;
  localparam int         IU  = 8;
  localparam logic [6:0] DEV = 7'h4C;
  localparam logic [2:0] ORD [7] = '{CH_REM1, CH_REM2, CH_LOCAL, CH_EXTERNAL_VOLTAGE_INPUT_3,
                                     CH_EXTERNAL_VOLTAGE_INPUT_2, CH_EXTERNAL_VOLTAGE_INPUT_1, CH_VCC};
  logic        clk_sys, reset, scl, host_oe, smb_data_out, smb_data_oe, pin_n, alert_pending;
  logic        reg_wr_stb, alert_served, busy, standby, acks;
  logic [7:0]  adc_sample, ext_rd_data, reg_addr, reg_wdata, base, old, cfg, q;
  logic [2:0]  conv_channel, r;
  logic [8:0]  lf;
  logic [20:0] seq;
  int          n_mismatch, tests_run, n_stb, n_srv, ncyc, blen, glen, cur_b, cur_g, k;
  wire         smb_data_in = ~(smb_data_oe | host_oe);

  monitor_smbus_conversion_control #(.TEMP_CONV_CYC(TC), .VOLT_CONV_CYC(VC),
    .IDLE_UNIT_CYC(IU), .EXTERNAL_VOLTAGE_INPUT_2_FIRST(1'b1)) monitor_smbus_conversion_control_inst (
    .clk_sys, .reset, .smb_clk(scl), .smb_data_in, .smb_data_out, .smb_data_oe,
    .standby_request_pin_n(pin_n), .slave_addr(DEV), .alert_pending, .adc_sample,
    .ext_rd_data, .reg_wr_stb, .reg_addr, .reg_wdata, .alert_served, .busy, .standby,
    .conv_channel);
  smbus_host_model smbus_host_model_inst (.clk_sys, .data_in(smb_data_in), .scl,
    .sda_oe(host_oe));

  always #2.5 clk_sys = ~clk_sys;

  // Slot values, strobe counts, cycle length, idle gap and slot order
  always @(negedge clk_sys) begin
    adc_sample <= base + {5'h00, conv_channel};
    n_stb += (reg_wr_stb === 1'b1);
    n_srv += (alert_served === 1'b1);
    if (busy === 1'b1) begin
      if (cur_b == 0) begin
        glen = cur_g;
        seq = {18'h00000, conv_channel};
      end else if (conv_channel !== seq[2:0]) begin
        seq = {seq[17:0], conv_channel};
      end
      cur_b++;
      cur_g = 0;
    end else begin
      if (cur_b != 0) begin
        blen = cur_b;
        ncyc++;
      end
      cur_b = 0;
      cur_g++;
    end
  end

  function automatic logic [8:0] lfsr_next(input logic [8:0] s);
    return {s[7:0], s[8] ^ s[4]};
  endfunction : lfsr_next

  // Slot order left after the disabled groups are dropped
  function automatic logic [20:0] exp_seq(input logic td, input logic vd);
    logic [20:0] s;
    s = '0;
    foreach (ORD[i]) if (ORD[i] < 3'h3 ? !td : !vd) s = {s[17:0], ORD[i]};
    return s;
  endfunction : exp_seq

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic cycles(input int n);
    int t;
    t = ncyc + n;
    for (int i = 0; i < 5000 && ncyc < t; i++) @(negedge clk_sys);
    chk("cycle end", 1, ncyc >= t);
  endtask : cycles

  task automatic bus(input int kind, input logic [7:0] c, input logic [7:0] d);
    smbus_host_model_inst.xfer(DEV, kind, c, d, q, acks);
    chk("ack", 1, acks);
    chk("data out", 0, smb_data_out);
  endtask : bus

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    {clk_sys, reset, pin_n, alert_pending} = 4'h7;
    ext_rd_data = 8'h5A;
    lf = 9'h174;
    base = lf[7:0];
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    cycles(2);
    chk("order", exp_seq(1'b0, 1'b0), seq);
    chk("busy len", 3 * TC + 4 * VC, blen);
    chk("idle gap", IU << 2, glen);
    bus(3, 8'h00, 8'h00);
    chk("recv local", base, q);
    $display("test reset done");
    for (int i = 0; i < NUM_CH; i++) begin
      bus(1, i[7:0], 8'h00);
      chk("result", base + i[7:0], q);
    end
    bus(3, 8'h00, 8'h00);
    chk("recv last", base + 8'h06, q);
    bus(2, {5'h00, CH_REM1}, 8'h00);
    bus(3, 8'h00, 8'h00);
    chk("recv sent", base + 8'h01, q);
    bus(1, 8'h0A, 8'h00);
    chk("ext read", ext_rd_data, q);
    $display("test pointer done");
    for (int i = 0; i < 3; i++) begin
      k = n_stb;
      cfg = 8'h20 >> i & 8'h30;
      bus(0, CMD_CONFIG, cfg);
      chk("strobes", k + 1, n_stb);
      chk("wr addr", CMD_CONFIG, reg_addr);
      chk("wr data", cfg, reg_wdata);
      cycles(2);
      chk("order", exp_seq(cfg[5], cfg[4]), seq);
      chk("busy len", (cfg[5] ? 0 : 3 * TC) + (cfg[4] ? 0 : 4 * VC), blen);
    end
    $display("test disables done");
    for (int i = 0; i < 3; i++) begin
      lf = lfsr_next(lf);
      r = i == 0 ? 3'h7 : i == 1 ? {1'b0, lf[1:0]} : 3'h0;
      bus(0, CMD_RATE, {5'h00, r});
      cycles(2);
      chk("idle gap", IU << r, glen);
      bus(1, CMD_RATE, 8'h00);
      chk("rate", r, q[2:0]);
    end
    $display("test rate done");
    for (int i = 0; i < 500 && busy !== 1'b1; i++) @(negedge clk_sys);
    lf = lfsr_next(lf);
    old = base;
    base = base ^ {1'b1, lf[6:0]};
    pin_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk("standby", 1, standby);
    chk("abort", 0, busy);
    k = ncyc;
    bus(1, 8'h01, 8'h00);
    chk("kept", old + 8'h01, q);
    bus(0, CMD_CONFIG, 8'h00);
    chk("pin wins", 1, standby);
    bus(1, CMD_STATUS, 8'h00);
    chk("status busy", 0, q[STAT_BUSY_BIT]);
    chk("no cycle", k, ncyc);
    pin_n = 1'b1;
    cycles(1);
    bus(1, 8'h01, 8'h00);
    chk("new result", base + 8'h01, q);
    bus(0, CMD_CONFIG, 8'h40);
    chk("sw standby", 1, standby);
    bus(1, CMD_CONFIG, 8'h00);
    chk("config", 8'h40, q);
    bus(0, CMD_CONFIG, 8'h00);
    chk("run", 0, standby);
    $display("test standby done");
    for (int i = 0; i < 3; i++) begin
      k = n_srv;
      alert_pending = i == 2;
      smbus_host_model_inst.xfer(i == 0 ? DEV ^ 7'h01 : ALERT_RESP_ADDR, 3, 8'h00, 8'h00,
                                 q, acks);
      chk("ack", i == 2, acks);
      chk("served", k + (i == 2), n_srv);
    end
    chk("alert addr", {DEV, 1'b0}, q);
    alert_pending = 1'b0;
    $display("test address done");
    print_verdict();
  end

  // Cuts a hang short
  initial begin
    repeat (90000) @(negedge clk_sys);
    n_mismatch++;
    $display("BAD watchdog expected done seen running");
    print_verdict();
  end
endmodule : monitor_smbus_conversion_control_test

/* File: tb/smbus_host_model.sv */
`timescale 1ns/100ps
// Bus master model; data only pulled low, clock idles high between frames
module smbus_host_model (
  input  wire logic clk_sys,
  input  wire logic data_in,
  output logic      scl,
  output logic      sda_oe
);
  localparam int Q = 8;
  logic [8:0] sh;
  initial {scl, sda_oe} = 2'b10;
  // Drive clock and data, then hold a quarter bit
  task automatic ph(input logic c, input logic d);
    scl = c;
    sda_oe = ~d;
    repeat (Q) @(negedge clk_sys);
  endtask : ph
  // Data falls while clock high; also the repeated start
  task automatic start();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
  endtask : start
  // Data rises while clock high
  task automatic stop();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask : stop
  // Eight bits MSB first, ninth clock with data released
  task automatic bt(input logic [7:0] d);
    logic [8:0] w;
    w = {d, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      ph(1'b0, w[i]);
      ph(1'b1, w[i]);
      sh = {sh[7:0], data_in};
      ph(1'b1, w[i]);
      ph(1'b0, w[i]);
    end
  endtask : bt
  // Kind 0 write, 1 read, 2 send, 3 receive; reads end with a not-acknowledge
  task automatic xfer(input logic [6:0] a, input int kind, input logic [7:0] c,
                      input logic [7:0] d, output logic [7:0] q, output logic ok);
    start();
    bt({a, kind == 3});
    ok = ~sh[0];
    if (kind < 3) bt(c);
    ok &= ~sh[0];
    if (kind == 0) bt(d);
    if (kind == 1) begin
      start();
      bt({a, 1'b1});
    end
    ok &= ~sh[0];
    if (kind[0]) bt(8'hFF);
    q = sh[8:1];
    stop();
  endtask : xfer
endmodule : smbus_host_model
